// file: hw/oau_unit.sv
// operand addressing unit: decodes modes and sequences extension and operand fetches
// ============================================================
`timescale 1ns/1ns
`default_nettype none
module oau_unit
   import oau_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   // instruction issue
   input wire logic start_i,
   input wire logic [15:0] instr_i,
   input wire logic [15:0] pc_i,
   input wire logic [15:0] src_reg_val_i,
   input wire logic [15:0] dst_reg_val_i,
   // memory read port, answered in the same cycle as the strobe
   input wire logic [15:0] mem_rdata_i,
   output logic mem_rd_o,
   output logic [15:0] mem_addr_o,
   // operand results
   output logic busy_o,
   output logic done_o,
   output logic [15:0] src_operand_o,
   output logic [15:0] dst_addr_o,
   output logic dst_is_mem_o,
   output logic [15:0] pc_next_o,
   output logic reg_wr_o,
   output logic [3:0] reg_wr_sel_o,
   output logic [15:0] reg_wr_val_o,
   output logic [2:0] cycles_o,
   output logic [1:0] words_o,
   // byte result path
   input wire logic [15:0] alu_result_i,
   output logic [15:0] wb_result_o,
   output logic wb_neg_o,
   output logic wb_zero_o
);
   oau_state_t state;
   logic [1:0] src_mode;
   logic [3:0] src_reg;
   logic [3:0] dst_reg;
   logic dst_mode;
   logic byte_op;
   logic [15:0] pc;
   logic [15:0] src_base;
   logic [15:0] dst_base;
   logic [15:0] next_src_val;
   logic is_const;
   logic src_ext;
   logic src_imm;
   logic src_ind;
   logic [2:0] next_cycles;
   logic [1:0] next_words;
   logic [1:0] ext_count;

   // ============================================================
   // decode of the held instruction
   logic [1:0] d_as;
   logic [3:0] d_sreg;
   logic [3:0] d_dreg;
   logic d_ad;
   assign d_as = instr_i[OAU_AS_LSB +: 2];
   assign d_sreg = instr_i[OAU_SREG_LSB +: 4];
   assign d_dreg = instr_i[OAU_DREG_LSB +: 4];
   assign d_ad = instr_i[OAU_AD_POS];

   // constant generators never reach the register file
   always_comb begin
      is_const = 1'b0;
      next_src_val = src_reg_val_i;
      if (d_sreg == OAU_REG_CG2) begin
         is_const = 1'b1;
         case (d_as)
            OAU_AS_REG: next_src_val = OAU_K_ZERO;
            OAU_AS_IDX: next_src_val = OAU_K_ONE;
            OAU_AS_IND: next_src_val = OAU_K_TWO;
            default: next_src_val = OAU_K_MONE;
         endcase
      end else if (d_sreg == OAU_REG_SR && d_as != OAU_AS_REG) begin
         is_const = (d_as != OAU_AS_IDX);
         case (d_as)
            OAU_AS_IDX: next_src_val = OAU_K_ZERO;
            OAU_AS_IND: next_src_val = OAU_K_FOUR;
            default: next_src_val = OAU_K_EIGHT;
         endcase
      end
   end

   // extension words needed by the source side
   logic d_src_ext;
   logic d_src_imm;
   // the constant generator with field 01 yields +1 and needs no extension word
   assign d_src_ext = (d_as == OAU_AS_IDX) && (d_sreg != OAU_REG_CG2);
   assign d_src_imm = (d_as == OAU_AS_AUTO) && (d_sreg == OAU_REG_PC);

   // first format timing, counted in core clock periods
   always_comb begin
      next_cycles = OAU_CYC_RR;
      next_words = 2'h1;
      if (d_src_ext && d_ad) begin
         next_cycles = OAU_CYC_XX;
         next_words = 2'h3;
      end else if (d_ad) begin
         next_cycles = OAU_CYC_RX;
         next_words = 2'h2;
      end else if (d_src_ext) begin
         next_cycles = OAU_CYC_XR;
         next_words = 2'h2;
      end else if (d_dreg == OAU_REG_PC) begin
         next_cycles = OAU_CYC_RPC;
      end
      if (d_src_imm && !(d_ad && d_src_ext)) begin
         next_words = next_words + 2'h1;
      end
   end

   // ============================================================
   // sequencer: source extension, source read, destination extension
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= OAU_IDLE;
      end else if (clk_en_i) begin
         case (state)
            OAU_IDLE: begin
               if (start_i) begin
                  if (d_src_ext || d_src_imm || (d_as[1] && !is_const)) begin
                     state <= (d_src_ext || d_src_imm) ? OAU_SRC_EXT : OAU_SRC_RD;
                  end else begin
                     state <= d_ad ? OAU_DST_EXT : OAU_DONE;
                  end
               end
            end
            OAU_SRC_EXT: state <= (src_ext) ? OAU_SRC_RD : (dst_mode ? OAU_DST_EXT : OAU_DONE);
            OAU_SRC_RD: state <= dst_mode ? OAU_DST_EXT : OAU_DONE;
            OAU_DST_EXT: state <= OAU_DONE;
            OAU_DONE: state <= OAU_IDLE;
            default: state <= OAU_IDLE;
         endcase
      end
   end

   // latched fields
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         src_mode <= OAU_AS_REG;
         src_reg <= 4'h0;
         dst_reg <= 4'h0;
         dst_mode <= 1'b0;
         byte_op <= 1'b0;
         src_ext <= 1'b0;
         src_imm <= 1'b0;
         src_ind <= 1'b0;
         src_base <= 16'h0000;
         dst_base <= 16'h0000;
         cycles_o <= 3'h0;
         words_o <= 2'h0;
      end else if (clk_en_i && state == OAU_IDLE && start_i) begin
         src_mode <= d_as;
         src_reg <= d_sreg;
         dst_reg <= d_dreg;
         dst_mode <= d_ad;
         byte_op <= instr_i[OAU_BW_POS];
         src_ext <= d_src_ext;
         src_imm <= d_src_imm;
         src_ind <= d_as[1] && !is_const && !d_src_imm;
         src_base <= next_src_val;
         dst_base <= (d_dreg == OAU_REG_SR) ? OAU_K_ZERO : dst_reg_val_i;
         cycles_o <= next_cycles;
         words_o <= next_words;
      end
   end

   // ============================================================
   // program counter, past the instruction word once issued
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc <= 16'h0000;
      end else if (clk_en_i) begin
         if (state == OAU_IDLE && start_i) begin
            pc <= pc_i + OAU_STEP_WORD;
         end else if (state == OAU_SRC_EXT || state == OAU_DST_EXT) begin
            pc <= pc + OAU_STEP_WORD;
         end
      end
   end

   // ============================================================
   // memory requests; the pc base is the extension word's own address
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_rd_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         ext_count <= 2'h0;
      end else if (clk_en_i) begin
         mem_rd_o <= 1'b0;
         case (state)
            OAU_SRC_EXT, OAU_DST_EXT: begin
               mem_rd_o <= 1'b1;
               mem_addr_o <= pc;
               ext_count <= ext_count + 2'h1;
            end
            OAU_SRC_RD: begin
               mem_rd_o <= 1'b1;
               if (src_ext) begin
                  mem_addr_o <= ((src_reg == OAU_REG_PC) ? (pc - OAU_STEP_WORD) : src_base)
                     + mem_rdata_i;
               end else begin
                  mem_addr_o <= src_base;
               end
            end
            default: ext_count <= 2'h0;
         endcase
      end
   end

   // ============================================================
   // operand results and pointer write-back
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         src_operand_o <= 16'h0000;
         dst_addr_o <= 16'h0000;
         dst_is_mem_o <= 1'b0;
         done_o <= 1'b0;
         busy_o <= 1'b0;
         pc_next_o <= 16'h0000;
         reg_wr_o <= 1'b0;
         reg_wr_sel_o <= 4'h0;
         reg_wr_val_o <= 16'h0000;
      end else if (clk_en_i) begin
         done_o <= (state == OAU_DONE);
         busy_o <= (state != OAU_IDLE) || start_i;
         reg_wr_o <= 1'b0;
         // source data stands one state after its read; with a memory
         // destination that state is the destination extension
         if (state == OAU_DST_EXT && (src_imm || src_ind || src_ext)) begin
            src_operand_o <= mem_rdata_i;
         end
         if (state == OAU_DONE) begin
            pc_next_o <= pc;
            dst_is_mem_o <= dst_mode;
            if (!(src_imm || src_ind || src_ext)) begin
               src_operand_o <= src_base;
            end else if (!dst_mode) begin
               src_operand_o <= mem_rdata_i;
            end
            if (src_ind && src_mode == OAU_AS_AUTO) begin
               // operand data has arrived before the pointer moves
               reg_wr_o <= 1'b1;
               reg_wr_sel_o <= src_reg;
               reg_wr_val_o <= src_base + (byte_op ? OAU_STEP_BYTE : OAU_STEP_WORD);
            end
         end
         if (state == OAU_DONE && dst_mode) begin
            // base register only read, never written back; pc already past the word
            dst_addr_o <= ((dst_reg == OAU_REG_PC) ? (pc - OAU_STEP_WORD) : dst_base)
               + mem_rdata_i;
         end
         if (state == OAU_DONE && !dst_mode) begin
            dst_addr_o <= {12'h000, dst_reg};
         end
      end
   end

   // ============================================================
   // write-back shaping for byte operations
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_result_o <= 16'h0000;
         wb_neg_o <= 1'b0;
         wb_zero_o <= 1'b0;
      end else if (clk_en_i) begin
         if (byte_op) begin
            wb_result_o <= alu_result_i & OAU_BYTE_MASK;
            wb_neg_o <= alu_result_i[7];
            wb_zero_o <= (alu_result_i[7:0] == 8'h00);
         end else begin
            wb_result_o <= alu_result_i;
            wb_neg_o <= alu_result_i[15];
            wb_zero_o <= (alu_result_i == 16'h0000);
         end
      end
   end

   // ============================================================
   // checks
   chk_byte_upper_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && byte_op |=> wb_result_o[15:8] == 8'h00)
      else $error("byte result upper byte not cleared");
   chk_pc_ext_step: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == OAU_DST_EXT |=> pc == $past(pc) + 16'h0002)
      else $error("pc did not step past extension word");
   chk_inc_after_fetch: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_wr_o |-> $past(state == OAU_DONE))
      else $error("pointer written before operand fetch");
   chk_const_no_read: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == OAU_IDLE && start_i && d_sreg == OAU_REG_CG2 && !d_ad
      |=> state == OAU_DONE)
      else $error("constant generator caused a fetch");
   chk_cycles_xx: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == OAU_IDLE && start_i && d_src_ext && d_ad
      |=> cycles_o == 3'h6 && words_o == 2'h3)
      else $error("indexed to indexed timing wrong");
   chk_cycles_rpc: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == OAU_IDLE && start_i && d_as == OAU_AS_REG && !d_ad
      && d_dreg == OAU_REG_PC |=> cycles_o == 3'h2)
      else $error("register to pc timing wrong");
   chk_src_before_dst: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == OAU_DST_EXT |-> $past(state) != OAU_IDLE || !src_ext)
      else $error("destination extension before source");
   chk_auto_step: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      reg_wr_o && $past(byte_op) |-> reg_wr_val_o == $past(src_base) + 16'h0001)
      else $error("byte autoincrement step wrong");
endmodule : oau_unit
`default_nettype wire

// file: hw/oau_pkg.sv
// package: constants and types of the operand addressing unit
package oau_pkg;
   // source mode field encodings
   localparam logic [1:0] OAU_AS_REG = 2'h0;
   localparam logic [1:0] OAU_AS_IDX = 2'h1;
   localparam logic [1:0] OAU_AS_IND = 2'h2;
   localparam logic [1:0] OAU_AS_AUTO = 2'h3;
   // special register numbers
   localparam logic [3:0] OAU_REG_PC = 4'h0;
   localparam logic [3:0] OAU_REG_SR = 4'h2;
   localparam logic [3:0] OAU_REG_CG2 = 4'h3;
   // instruction field positions
   localparam int OAU_SREG_LSB = 8;
   localparam int OAU_AD_POS = 7;
   localparam int OAU_BW_POS = 6;
   localparam int OAU_AS_LSB = 4;
   localparam int OAU_DREG_LSB = 0;
   // constant generator values
   localparam logic [15:0] OAU_K_ZERO = 16'h0000;
   localparam logic [15:0] OAU_K_ONE = 16'h0001;
   localparam logic [15:0] OAU_K_TWO = 16'h0002;
   localparam logic [15:0] OAU_K_FOUR = 16'h0004;
   localparam logic [15:0] OAU_K_EIGHT = 16'h0008;
   localparam logic [15:0] OAU_K_MONE = 16'hffff;
   // increments and cycle counts of the first format
   localparam logic [15:0] OAU_STEP_WORD = 16'h0002;
   localparam logic [15:0] OAU_STEP_BYTE = 16'h0001;
   localparam logic [15:0] OAU_BYTE_MASK = 16'h00ff;
   localparam logic [2:0] OAU_CYC_RR = 3'h1;
   localparam logic [2:0] OAU_CYC_RPC = 3'h2;
   localparam logic [2:0] OAU_CYC_XR = 3'h3;
   localparam logic [2:0] OAU_CYC_RX = 3'h4;
   localparam logic [2:0] OAU_CYC_XX = 3'h6;
   typedef enum logic [2:0] {
      OAU_IDLE, OAU_SRC_EXT, OAU_SRC_RD, OAU_DST_EXT, OAU_DONE
   } oau_state_t;
endpackage : oau_pkg

// file: tb/operand_addressing_unit_bench.sv
// testbench of the operand addressing unit, driven directly at its ports
`timescale 1ns/1ns
`default_nettype none
module operand_addressing_unit_bench;
   import oau_pkg::*;
   // ============================================================
   // signals
   logic core_clk_i, arst_n_i, clk_en_i, start_i;
   logic [15:0] instr_i, pc_i, src_reg_val_i, dst_reg_val_i, mem_rdata_i, alu_result_i;
   logic mem_rd_o, busy_o, done_o, dst_is_mem_o, reg_wr_o, wb_neg_o, wb_zero_o;
   logic [15:0] mem_addr_o, src_operand_o, dst_addr_o, pc_next_o, reg_wr_val_o, wb_result_o;
   logic [3:0] reg_wr_sel_o;
   logic [2:0] cycles_o;
   logic [1:0] words_o;
   int err_total;
   int checks;
   logic [15:0] mem [logic [15:0]];
   logic [15:0] rd_q [$];

   oau_unit dut (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
      .start_i(start_i), .instr_i(instr_i), .pc_i(pc_i),
      .src_reg_val_i(src_reg_val_i), .dst_reg_val_i(dst_reg_val_i),
      .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
      .busy_o(busy_o), .done_o(done_o), .src_operand_o(src_operand_o),
      .dst_addr_o(dst_addr_o), .dst_is_mem_o(dst_is_mem_o), .pc_next_o(pc_next_o),
      .reg_wr_o(reg_wr_o), .reg_wr_sel_o(reg_wr_sel_o), .reg_wr_val_o(reg_wr_val_o),
      .cycles_o(cycles_o), .words_o(words_o), .alu_result_i(alu_result_i),
      .wb_result_o(wb_result_o), .wb_neg_o(wb_neg_o), .wb_zero_o(wb_zero_o)
   );

   initial begin
      core_clk_i = 1'h0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // ============================================================
   // memory: data stands while the strobe stands; between reads the data
   // follows the address scrambled so a late capture never matches by luck
   always @(posedge core_clk_i) begin
      if (mem_rd_o === 1'h1) begin
         rd_q.push_back(mem_addr_o);
      end
   end

   always @(mem_rd_o, mem_addr_o) begin
      if (mem_rd_o === 1'h1) begin
         mem_rdata_i = mem.exists(mem_addr_o) ? mem[mem_addr_o] : ~mem_addr_o;
      end else begin
         mem_rdata_i = mem_addr_o ^ 16'h5a5a;
      end
   end

   // ============================================================
   // helpers
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   function logic [15:0] mk(input logic [3:0] s, input logic ad, input logic bw,
                            input logic [1:0] md, input logic [3:0] d);
      return {4'h4, s, ad, bw, md, d};
   endfunction : mk

   task run(input logic [15:0] ins, input logic [15:0] pc, input logic [15:0] sv,
            input logic [15:0] dv);
      int n;
      rd_q.delete();
      @(posedge core_clk_i);
      instr_i <= ins;
      pc_i <= pc;
      src_reg_val_i <= sv;
      dst_reg_val_i <= dv;
      start_i <= 1'h1;
      @(posedge core_clk_i);
      start_i <= 1'h0;
      #1;
      chk({15'h0, busy_o}, 16'h1, "busy");
      n = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         n++;
      end while (done_o !== 1'h1 && n < 12);
      if (done_o !== 1'h1) begin
         err_total++;
         $display("Error at %0t: no completion", $time);
      end
   endtask : run

   task fmt(input logic [2:0] c, input logic [1:0] w, input logic [15:0] pcn);
      chk({13'h0, cycles_o}, {13'h0, c}, "cycles");
      chk({14'h0, words_o}, {14'h0, w}, "words");
      chk(pc_next_o, pcn, "next pc");
   endtask : fmt

   // ============================================================
   // scenarios
   task t_reg_reg;
      run(mk(4'h5, 1'h0, 1'h0, 2'h0, 4'h8), 16'h1000, 16'ha023, 16'hfa15);
      chk(src_operand_o, 16'ha023, "reg operand");
      chk(dst_addr_o, 16'h0008, "dst reg");
      chk(16'(rd_q.size()), 16'h0, "reads");
      fmt(3'h1, 2'h1, 16'h1002);
      run(mk(4'h5, 1'h0, 1'h0, 2'h0, OAU_REG_PC), 16'h1000, 16'h2000, 16'h1000);
      chk({13'h0, cycles_o}, 16'h2, "pc dst cycles");
   endtask : t_reg_reg

   task t_indexed;
      mem[16'h1002] = 16'h0002;
      mem[16'h0202] = 16'ha123;
      run(mk(4'h5, 1'h0, 1'h0, 2'h1, 4'h7), 16'h1000, 16'h0200, 16'h0);
      chk(rd_q[0], 16'h1002, "src ext addr");
      chk(rd_q[1], 16'h0202, "src addr");
      chk(src_operand_o, 16'ha123, "src data");
      chk({15'h0, reg_wr_o}, 16'h0, "base write");
      fmt(3'h3, 2'h2, 16'h1004);
      mem[16'hff14] = 16'hf102;
      mem[16'hf016] = 16'h0a5c;
      run(mk(OAU_REG_PC, 1'h0, 1'h0, 2'h1, 4'h6), 16'hff12, 16'hff12, 16'h0);
      chk(rd_q[1], 16'hf016, "symbolic addr");
      chk(src_operand_o, 16'h0a5c, "symbolic data");
      mem[16'h2002] = 16'hf016;
      run(mk(OAU_REG_SR, 1'h0, 1'h0, 2'h1, 4'h6), 16'h2000, 16'h0107, 16'h0);
      chk(rd_q[1], 16'hf016, "absolute addr");
      fmt(3'h3, 2'h2, 16'h2004);
   endtask : t_indexed

   task t_dst_mem;
      mem[16'h1002] = 16'h0006;
      run(mk(4'h5, 1'h1, 1'h0, 2'h0, 4'h6), 16'h1000, 16'ha023, 16'h0100);
      chk(dst_addr_o, 16'h0106, "dst addr");
      chk({15'h0, dst_is_mem_o}, 16'h1, "dst in memory");
      fmt(3'h4, 2'h2, 16'h1004);
      mem[16'h3002] = 16'h0002;
      mem[16'h3004] = 16'h0006;
      mem[16'h0402] = 16'hc0de;
      run(mk(4'h5, 1'h1, 1'h0, 2'h1, 4'h6), 16'h3000, 16'h0400, 16'h0500);
      chk(16'(rd_q.size()), 16'h3, "reads");
      chk(rd_q[0], 16'h3002, "src ext first");
      chk(rd_q[1], 16'h0402, "src addr");
      chk(rd_q[2], 16'h3004, "dst ext last");
      chk(dst_addr_o, 16'h0506, "dst addr");
      chk(src_operand_o, 16'hc0de, "src data");
      fmt(3'h6, 2'h3, 16'h3006);
   endtask : t_dst_mem

   task t_pointer;
      mem[16'hfa32] = 16'h5bc1;
      run(mk(4'ha, 1'h0, 1'h0, 2'h2, 4'hb), 16'h1000, 16'hfa32, 16'h0);
      chk(rd_q[0], 16'hfa32, "indirect addr");
      chk(src_operand_o, 16'h5bc1, "indirect data");
      chk({15'h0, reg_wr_o}, 16'h0, "no write");
      fmt(3'h1, 2'h1, 16'h1002);
      for (int b = 0; b < 2; b++) begin
         run(mk(4'ha, 1'h0, b[0], 2'h3, 4'hb), 16'h1000, 16'hfa32, 16'h0);
         chk(rd_q[0], 16'hfa32, "autoinc fetch");
         chk(src_operand_o, 16'h5bc1, "autoinc data");
         chk({15'h0, reg_wr_o}, 16'h1, "pointer write");
         chk({12'h0, reg_wr_sel_o}, 16'h000a, "pointer sel");
         chk(reg_wr_val_o, b ? 16'hfa33 : 16'hfa34, "pointer step");
      end
      mem[16'hff14] = 16'h0045;
      run(mk(OAU_REG_PC, 1'h0, 1'h0, 2'h3, 4'h9), 16'hff12, 16'hff12, 16'h0);
      chk(rd_q[0], 16'hff14, "immediate addr");
      chk(src_operand_o, 16'h0045, "immediate data");
      fmt(3'h1, 2'h2, 16'hff16);
   endtask : t_pointer

   task t_constgen;
      logic [3:0] cs [6] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2};
      logic [1:0] cm [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
      logic [15:0] cv [6] = '{16'h0, 16'h1, 16'h2, 16'hffff, 16'h4, 16'h8};
      for (int i = 0; i < 6; i++) begin
         run(mk(cs[i], 1'h0, 1'h0, cm[i], 4'h9), 16'h1000, 16'h1234, 16'h0);
         chk(src_operand_o, cv[i], "constant");
         chk(16'(rd_q.size()), 16'h0, "const reads");
         chk({14'h0, words_o}, 16'h1, "const words");
      end
   endtask : t_constgen

   task t_byte;
      run(mk(4'h5, 1'h0, 1'h1, 2'h0, 4'h8), 16'h1000, 16'h1280, 16'h0);
      @(posedge core_clk_i);
      alu_result_i <= 16'h1280;
      @(posedge core_clk_i);
      #1;
      chk(wb_result_o, 16'h0080, "byte result");
      chk({14'h0, wb_neg_o, wb_zero_o}, 16'h2, "byte flags");
      @(posedge core_clk_i);
      alu_result_i <= 16'hff00;
      @(posedge core_clk_i);
      #1;
      chk(wb_result_o, 16'h0000, "byte result");
      chk({14'h0, wb_neg_o, wb_zero_o}, 16'h1, "byte flags");
   endtask : t_byte

   // ============================================================
   // run control
   task complete_run;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   initial begin
      err_total = 0;
      checks = 0;
      arst_n_i = 1'h0;
      clk_en_i = 1'h1;
      start_i = 1'h0;
      instr_i = 16'h0;
      pc_i = 16'h0;
      src_reg_val_i = 16'h0;
      dst_reg_val_i = 16'h0;
      alu_result_i = 16'h0;
      repeat (3) @(posedge core_clk_i);
      arst_n_i <= 1'h1;
      t_reg_reg();
      t_indexed();
      t_dst_mem();
      t_pointer();
      t_constgen();
      t_byte();
      complete_run();
   end

   // 18 operations of under 10 cycles each; ample margin
   initial begin
      #(100 * 2000);
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : operand_addressing_unit_bench
`default_nettype wire
